// ===== hw/tcp_defines.vh
// register map, field positions and reset values of the timer block
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCP_IDX_CONTROL   8'h88
`define TCP_IDX_MODE      8'h89
`define TCP_IDX_T0_LOW    8'h8A
`define TCP_IDX_T1_LOW    8'h8B
`define TCP_IDX_T0_HIGH   8'h8C
`define TCP_IDX_T1_HIGH   8'h8D
`define TCP_IDX_EXTRA     8'h91
`define TCP_IDX_CLKCFG    8'hA1
`define TCP_IDX_T2_CTRL   8'hC8
`define TCP_IDX_T2_RLOW   8'hCA
`define TCP_IDX_T2_RHIGH  8'hCB
`define TCP_IDX_T2_CLOW   8'hCC
`define TCP_IDX_T2_CHIGH  8'hCD

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCP_CTL_TF1       7
`define TCP_CTL_TR1       6
`define TCP_CTL_TF0       5
`define TCP_CTL_TR0       4
`define TCP_MOD_GATE      3
`define TCP_MOD_CT        2
`define TCP_EXT_TOG0      0
`define TCP_EXT_TOG1      1
`define TCP_CFG_COMPAT    3
`define TCP_T2_TF2        7
`define TCP_T2_TIMER2_EXTRA_FLAG       6
`define TCP_T2_RUN        5
`define TCP_T2_EXEN       4
`define TCP_T2_UPDOWN_ENABLE       3

// ----------------------------------------------------------------
// mode codes and reset values
// ----------------------------------------------------------------
`define TCP_MODE_13BIT    2'h0
`define TCP_MODE_16BIT    2'h1
`define TCP_MODE_RELOAD   2'h2
`define TCP_MODE_SPLIT    2'h3
`define TCP_CM_RELOAD     2'h0
`define TCP_FAST_CDV      3'h0
`define TCP_FAST_TPS      4'h0
`define TCP_COMPAT_CDV    3'h2
`define TCP_COMPAT_TPS    4'h5
`define TCP_STRAP_WAIT    2'h2

`endif

// ===== hw/tcp_channel.v
// one 16-bit timer/counter with its four operating modes
`timescale 1ns/1ps
`include "tcp_defines.vh"

module tcp_channel (
    // clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // count sources and controls
    input  wire       cnt_tick,
    input  wire       pin_fall,
    input  wire       ct_sel,
    input  wire [1:0] mode,
    input  wire       gate_en,
    input  wire       gate_lvl,
    input  wire       run,
    input  wire       run_high,
    // software load
    input  wire       wr_low,
    input  wire       wr_high,
    input  wire [7:0] wdata,
    // count and overflow
    output reg  [7:0] count_low_q,
    output reg  [7:0] count_high_q,
    output wire       ovf_low,
    output wire       ovf_high
);

// count step: timer ticks or pin falls, gated by run and gate pin
wire go    = run & (~gate_en | gate_lvl)
           & (ct_sel ? pin_fall : cnt_tick);
wire go_hi = run_high & cnt_tick;
wire lo5   = &count_low_q[4:0];
wire lo8   = &count_low_q;

// overflow of the main counter in the selected width
assign ovf_low  = go & ((mode == `TCP_MODE_13BIT) ? (lo5 & &count_high_q) :
                        (mode == `TCP_MODE_16BIT) ? (lo8 & &count_high_q) :
                        lo8);
assign ovf_high = (mode == `TCP_MODE_SPLIT) & go_hi & &count_high_q;

// count registers: a software write wins over counting
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        count_low_q  <= 8'h00;
        count_high_q <= 8'h00;
    end else begin
        if (wr_low) begin
            count_low_q <= wdata;
        end else if (go) begin
            case (mode)
                `TCP_MODE_13BIT:
                    count_low_q[4:0] <= count_low_q[4:0] + 5'h01;
                `TCP_MODE_RELOAD:
                    count_low_q <= lo8 ? count_high_q
                                       : count_low_q + 8'h01;
                default: count_low_q <= count_low_q + 8'h01;
            endcase
        end
        if (wr_high) begin
            count_high_q <= wdata;
        end else begin
            case (mode)
                `TCP_MODE_13BIT:
                    if (go && lo5) count_high_q <= count_high_q + 8'h01;
                `TCP_MODE_16BIT:
                    if (go && lo8) count_high_q <= count_high_q + 8'h01;
                `TCP_MODE_SPLIT:
                    if (go_hi) count_high_q <= count_high_q + 8'h01;
                default: count_high_q <= count_high_q;
            endcase
        end
    end
end

endmodule // tcp_channel

// ===== hw/tcp_updown.v
// third timer: 16-bit up/down counter with reload register
`timescale 1ns/1ps
`include "tcp_defines.vh"

module tcp_updown (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // controls
    input  wire        cnt_tick,
    input  wire        run,
    input  wire        updown_enable,
    input  wire        external_input_enable,
    input  wire        dir_lvl,
    input  wire [1:0]  compare_mode,
    // software access
    input  wire        wr_flags,
    input  wire        wr_clow,
    input  wire        wr_chigh,
    input  wire        wr_rlow,
    input  wire        wr_rhigh,
    input  wire [7:0]  wdata,
    // state
    output reg  [15:0] count_q,
    output reg  [15:0] reload_q,
    output reg         overflow_flag_q,
    output reg         extra_flag_q
);

// direction: pin decides only when both enables are set
wire down = updown_enable & external_input_enable & ~dir_lvl;
wire go   = run & cnt_tick;
wire ovf  = go & ~down & (&count_q) & (compare_mode == `TCP_CM_RELOAD);
wire unf  = go & down & (count_q == reload_q);
wire evt  = ovf | unf;

// count and reload registers
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        count_q  <= 16'h0000;
        reload_q <= 16'h0000;
    end else begin
        if (wr_rlow)  reload_q[7:0]  <= wdata;
        if (wr_rhigh) reload_q[15:8] <= wdata;
        if (wr_clow || wr_chigh) begin
            if (wr_clow)  count_q[7:0]  <= wdata;
            if (wr_chigh) count_q[15:8] <= wdata;
        end else if (ovf) begin
            count_q <= reload_q;
        end else if (unf) begin
            count_q <= 16'hFFFF;
        end else if (go) begin
            count_q <= down ? count_q - 16'h0001 : count_q + 16'h0001;
        end
    end
end

// flags: a hardware event wins over a software write
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        overflow_flag_q <= 1'b0;
        extra_flag_q    <= 1'b0;
    end else begin
        if (evt)
            overflow_flag_q <= 1'b1;
        else if (wr_flags)
            overflow_flag_q <= wdata[`TCP_T2_TF2];
        // extra flag is a 17th count bit, it requests nothing
        if (evt && updown_enable)
            extra_flag_q <= ~extra_flag_q;
        else if (wr_flags)
            extra_flag_q <= wdata[`TCP_T2_TIMER2_EXTRA_FLAG];
    end
end

endmodule // tcp_updown

// ===== hw/tcp_timer_block.v
// timer/counter block top: bus slave, prescaler, pins, three timers
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "tcp_defines.vh"

// Summary of operation
// - in timer function each counter advances once per prescaled tick
// - one prescaler, divisor 1 to 16, feeds all three timers
// - compatibility mode starts with divider 2 and prescaler 6
// - fast mode starts with divider and prescale select both 0
// - in counter function a falling edge on the count pin counts
// - fast mode samples the pin on each system clock divider tick, high then low counts
// - in fast mode with divider select 0 the new count shows after the third clock edge following the pin's falling edge
// - compatibility mode samples count pins on each prescaler tick
// - four modes: 13-bit, 16-bit, 8-bit auto-reload, split
// - per timer a counter select bit and two-bit mode field
// - split mode yields two 8-bit timers and one 16-bit timer
// - timers 0 and 1 may each toggle an output pin on overflow
// - gated timers run only while their gate pin is high
// - timer 1 overflows serve as the serial baud source
// - with both enables set the direction pin picks up or down
// - counting up with compare mode 00 overflows at max and reloads
// - counting down underflows at reload value, then loads max
// - up/down mode toggles the extra flag on each wrap
// - the extra flag toggle raises no interrupt request
module tcp_timer_block (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // avalon-mm slave
    input  wire [9:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // external pins
    input  wire        compat_mode,
    input  wire        timer0_count_pin,
    input  wire        timer1_count_pin,
    input  wire        timer0_gate_pin,
    input  wire        timer1_gate_pin,
    input  wire        timer2_direction_pin,
    // outputs
    output reg         timer0_toggle_out,
    output reg         timer1_toggle_out,
    output reg         baud_tick
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
wire [5:0] pins_raw = {compat_mode, timer2_direction_pin,
                       timer1_gate_pin, timer0_gate_pin,
                       timer1_count_pin, timer0_count_pin};
reg  [5:0] pins_m_q;
reg  [5:0] pins_q;

// two flops before any logic looks at a pin
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        pins_m_q <= 6'h00;
        pins_q   <= 6'h00;
    end else begin
        pins_m_q <= pins_raw;
        pins_q   <= pins_m_q;
    end
end

// ----------------------------------------------------------------
// bus slave
// ----------------------------------------------------------------
reg        ack_q;
wire [7:0] idx  = address[9:2];
wire       req  = read | write;
wire       wen  = write & ack_q & byteenable[0] & (address[1:0] == 2'h0);
wire [7:0] wd   = writedata[7:0];

// one wait state on every access
assign waitrequest = req & ~ack_q;

always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
        ack_q <= 1'b0;
    else
        ack_q <= req & ~ack_q;
end

// write strobes, one per register
wire wr_ctl  = wen & (idx == `TCP_IDX_CONTROL);
wire wr_mod  = wen & (idx == `TCP_IDX_MODE);
wire wr_l0   = wen & (idx == `TCP_IDX_T0_LOW);
wire wr_l1   = wen & (idx == `TCP_IDX_T1_LOW);
wire wr_h0   = wen & (idx == `TCP_IDX_T0_HIGH);
wire wr_h1   = wen & (idx == `TCP_IDX_T1_HIGH);
wire wr_ext  = wen & (idx == `TCP_IDX_EXTRA);
wire wr_cfg  = wen & (idx == `TCP_IDX_CLKCFG);
wire wr_t2c  = wen & (idx == `TCP_IDX_T2_CTRL);
wire wr_t2rl = wen & (idx == `TCP_IDX_T2_RLOW);
wire wr_t2rh = wen & (idx == `TCP_IDX_T2_RHIGH);
wire wr_t2cl = wen & (idx == `TCP_IDX_T2_CLOW);
wire wr_t2ch = wen & (idx == `TCP_IDX_T2_CHIGH);

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
reg  [7:0] control_q;
reg  [7:0] mode_q;
reg  [7:0] extra_q;
reg  [2:0] cdv_q;
reg  [3:0] tps_q;
reg        compat_q;
reg  [1:0] strap_cnt_q;
reg        strap_done_q;
reg  [5:0] t2ctl_q;
wire       tf0_set;
wire       tf1_set;

// mode register, extra mode and timer 2 control bits
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        mode_q  <= 8'h00;
        extra_q <= 8'h00;
        t2ctl_q <= 6'h00;
    end else begin
        if (wr_mod) mode_q  <= wd;
        if (wr_ext) extra_q <= wd;
        if (wr_t2c) t2ctl_q <= wd[5:0];
    end
end

// control register: overflow sets a flag, set beats a clear
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        control_q <= 8'h00;
    end else begin
        if (wr_ctl) control_q <= wd;
        if (tf0_set) control_q[`TCP_CTL_TF0] <= 1'b1;
        if (tf1_set) control_q[`TCP_CTL_TF1] <= 1'b1;
    end
end

// clock setup: defaults follow the synchronised mode strap
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cdv_q        <= `TCP_FAST_CDV;
        tps_q        <= `TCP_FAST_TPS;
        compat_q     <= 1'b0;
        strap_cnt_q  <= 2'h0;
        strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        if (strap_cnt_q == `TCP_STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            compat_q     <= pins_q[5];
            if (pins_q[5]) begin
                cdv_q <= `TCP_COMPAT_CDV;
                tps_q <= `TCP_COMPAT_TPS;
            end else begin
                cdv_q <= `TCP_FAST_CDV;
                tps_q <= `TCP_FAST_TPS;
            end
        end
    end else if (wr_cfg) begin
        cdv_q <= wd[2:0];
        tps_q <= wd[7:4];
    end
end

// ----------------------------------------------------------------
// system clock divider and shared prescaler
// ----------------------------------------------------------------
reg  [2:0] sys_cnt_q;
reg  [3:0] pre_cnt_q;
wire       sys_tick = (cdv_q == 3'h0) || (sys_cnt_q >= cdv_q - 3'h1);
wire       pre_tick = sys_tick & (pre_cnt_q >= tps_q);

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        sys_cnt_q <= 3'h0;
        pre_cnt_q <= 4'h0;
    end else begin
        sys_cnt_q <= sys_tick ? 3'h0 : sys_cnt_q + 3'h1;
        if (sys_tick)
            pre_cnt_q <= (pre_cnt_q >= tps_q) ? 4'h0
                                              : pre_cnt_q + 4'h1;
    end
end

// ----------------------------------------------------------------
// count pin edge detection
// ----------------------------------------------------------------
// fast mode samples per system divider tick, compatibility mode per prescale
wire       samp_stb = compat_q ? pre_tick : sys_tick;
reg  [1:0] samp_q;
wire [1:0] pin_fall = {2{samp_stb}} & samp_q & ~pins_q[1:0];

// a fall taken here moves the count at the same edge
always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
        samp_q <= 2'h0;
    else if (samp_stb)
        samp_q <= pins_q[1:0];
end

// ----------------------------------------------------------------
// timer 0 and timer 1
// ----------------------------------------------------------------
wire [7:0] t0_low;
wire [7:0] t0_high;
wire [7:0] t1_low;
wire [7:0] t1_high;
wire       t0_ovf;
wire       t0_ovf_hi;
wire       t1_ovf;
wire       split0   = mode_q[1:0] == `TCP_MODE_SPLIT;
// timer 1 holds its count when asked for split mode
wire       t1_run   = control_q[`TCP_CTL_TR1]
                    & (mode_q[5:4] != `TCP_MODE_SPLIT);

tcp_channel u_timer0 (
    .clk          (clk),
    .arst_n       (arst_n),
    .cnt_tick     (pre_tick),
    .pin_fall     (pin_fall[0]),
    .ct_sel       (mode_q[`TCP_MOD_CT]),
    .mode         (mode_q[1:0]),
    .gate_en      (mode_q[`TCP_MOD_GATE]),
    .gate_lvl     (pins_q[2]),
    .run          (control_q[`TCP_CTL_TR0]),
    .run_high     (control_q[`TCP_CTL_TR1]),
    .wr_low       (wr_l0),
    .wr_high      (wr_h0),
    .wdata        (wd),
    .count_low_q  (t0_low),
    .count_high_q (t0_high),
    .ovf_low      (t0_ovf),
    .ovf_high     (t0_ovf_hi)
);

tcp_channel u_timer1 (
    .clk          (clk),
    .arst_n       (arst_n),
    .cnt_tick     (pre_tick),
    .pin_fall     (pin_fall[1]),
    .ct_sel       (mode_q[`TCP_MOD_CT + 4]),
    .mode         (mode_q[5:4]),
    .gate_en      (mode_q[`TCP_MOD_GATE + 4]),
    .gate_lvl     (pins_q[3]),
    .run          (t1_run),
    .run_high     (1'b0),
    .wr_low       (wr_l1),
    .wr_high      (wr_h1),
    .wdata        (wd),
    .count_low_q  (t1_low),
    .count_high_q (t1_high),
    .ovf_low      (t1_ovf),
    .ovf_high     ()
);

// in split mode the high byte of timer 0 sets the timer 1 flag
assign tf0_set = t0_ovf;
assign tf1_set = t1_ovf | (split0 & t0_ovf_hi);

// overflow pin toggles and the serial baud pulse
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        timer0_toggle_out <= 1'b0;
        timer1_toggle_out <= 1'b0;
        baud_tick         <= 1'b0;
    end else begin
        if (tf0_set && extra_q[`TCP_EXT_TOG0])
            timer0_toggle_out <= ~timer0_toggle_out;
        if (tf1_set && extra_q[`TCP_EXT_TOG1])
            timer1_toggle_out <= ~timer1_toggle_out;
        baud_tick <= t1_ovf;
    end
end

// ----------------------------------------------------------------
// timer 2
// ----------------------------------------------------------------
wire [15:0] t2_count;
wire [15:0] t2_reload;
wire        t2_tf;
wire        t2_exf;

tcp_updown u_timer2 (
    .clk                   (clk),
    .arst_n                (arst_n),
    .cnt_tick              (pre_tick),
    .run                   (t2ctl_q[`TCP_T2_RUN]),
    .updown_enable         (t2ctl_q[`TCP_T2_UPDOWN_ENABLE]),
    .external_input_enable (t2ctl_q[`TCP_T2_EXEN]),
    .dir_lvl               (pins_q[4]),
    .compare_mode          (t2ctl_q[1:0]),
    .wr_flags              (wr_t2c),
    .wr_clow               (wr_t2cl),
    .wr_chigh              (wr_t2ch),
    .wr_rlow               (wr_t2rl),
    .wr_rhigh              (wr_t2rh),
    .wdata                 (wd),
    .count_q               (t2_count),
    .reload_q              (t2_reload),
    .overflow_flag_q       (t2_tf),
    .extra_flag_q          (t2_exf)
);

// ----------------------------------------------------------------
// read back
// ----------------------------------------------------------------
reg [7:0] rd_mux;

// unmapped or misaligned addresses read as zero
always @* begin
    if (address[1:0] != 2'h0)
        rd_mux = 8'h00;
    else if (idx == `TCP_IDX_CONTROL)
        rd_mux = control_q;
    else if (idx == `TCP_IDX_MODE)
        rd_mux = mode_q;
    else if (idx == `TCP_IDX_T0_LOW)
        rd_mux = t0_low;
    else if (idx == `TCP_IDX_T1_LOW)
        rd_mux = t1_low;
    else if (idx == `TCP_IDX_T0_HIGH)
        rd_mux = t0_high;
    else if (idx == `TCP_IDX_T1_HIGH)
        rd_mux = t1_high;
    else if (idx == `TCP_IDX_EXTRA)
        rd_mux = extra_q;
    else if (idx == `TCP_IDX_CLKCFG)
        rd_mux = {tps_q, compat_q, cdv_q};
    else if (idx == `TCP_IDX_T2_CTRL)
        rd_mux = {t2_tf, t2_exf, t2ctl_q};
    else if (idx == `TCP_IDX_T2_RLOW)
        rd_mux = t2_reload[7:0];
    else if (idx == `TCP_IDX_T2_RHIGH)
        rd_mux = t2_reload[15:8];
    else if (idx == `TCP_IDX_T2_CLOW)
        rd_mux = t2_count[7:0];
    else if (idx == `TCP_IDX_T2_CHIGH)
        rd_mux = t2_count[15:8];
    else
        rd_mux = 8'h00;
end

// read data is captured in the wait cycle and stands at the answer
always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
        readdata <= 32'h0000_0000;
    else if (read && !ack_q)
        readdata <= {24'h00_0000, rd_mux};
end

endmodule // tcp_timer_block

// ===== testbench/tcp_timer_checker.sv
// bus and output timing checker bound to the timer block top
`timescale 1ns/1ps
module tcp_timer_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // avalon-mm slave
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // outputs
    input wire logic        timer0_toggle_out,
    input wire logic        timer1_toggle_out,
    input wire logic        baud_tick
);
    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_req_wait; (read || write) && waitrequest; endsequence
    sequence s_req_done; (read || write) && !waitrequest; endsequence
    property p_wait_one; s_req_wait |=> s_req_done; endproperty
    property p_wait_new; ($rose(read) || $rose(write)) |-> waitrequest;
    endproperty
    property p_wait_idle; !(read || write) |-> !waitrequest; endproperty
    property p_rd_upper; s_req_done ##0 read |-> readdata[31:8] == 24'h0;
    endproperty
    property p_rd_misalign;
        s_req_done ##0 (read && address[1:0] != 2'b00) |-> readdata == 32'h0;
    endproperty
    property p_rd_unmapped;
        s_req_done ##0 (read && address[9:2] < 8'h88) |-> readdata == 32'h0;
    endproperty
    property p_rd_stand; !(read && waitrequest) |=> $stable(readdata);
    endproperty
    property p_out_rst;
        $rose(arst_n) |-> !timer0_toggle_out && !timer1_toggle_out && !baud_tick;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("request waited more than one cycle");
    a_wait_new: assert property (p_wait_new)
        else $error("new request got no wait state");
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest high with no request");
    a_rd_upper: assert property (p_rd_upper)
        else $error("read data upper bits not zero");
    a_rd_misalign: assert property (p_rd_misalign)
        else $error("misaligned read returned data");
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read returned data");
    a_rd_stand: assert property (p_rd_stand)
        else $error("read data changed without a read");
    a_out_rst: assert property (p_out_rst)
        else $error("outputs not idle after reset");
endmodule // tcp_timer_checker

bind tcp_timer_block tcp_timer_checker i_chk (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .timer0_toggle_out(timer0_toggle_out),
    .timer1_toggle_out(timer1_toggle_out), .baud_tick(baud_tick)
);

// ===== testbench/tcp_pin_model.sv
// external count, gate, direction and strap pins around the block
`timescale 1ns/1ps
module tcp_pin_model (
    // clock
    input  wire logic clk,
    // pins
    output logic      compat_mode,
    output logic      timer0_count_pin,
    output logic      timer1_count_pin,
    output logic      timer0_gate_pin,
    output logic      timer1_gate_pin,
    output logic      timer2_direction_pin
);
    // idle levels: count pins high, gates open, counting up
    initial begin
        compat_mode = 1'b0;
        timer0_count_pin = 1'b1;
        timer1_count_pin = 1'b1;
        timer0_gate_pin = 1'b1;
        timer1_gate_pin = 1'b1;
        timer2_direction_pin = 1'b1;
    end
    // n falling edges, low held for hold cycles, high for one cycle more
    task automatic falls(input int n, input int hold);
        repeat (n) begin
            @(posedge clk) timer0_count_pin <= 1'b0;
            repeat (hold) @(posedge clk);
            timer0_count_pin <= 1'b1;
            repeat (hold) @(posedge clk);
        end
    endtask
    // direction level, changed after an edge
    task automatic set_dir(input logic v);
        @(posedge clk) timer2_direction_pin <= v;
    endtask
    // strap level, set before a reset
    task automatic set_strap(input logic v);
        @(posedge clk) compat_mode <= v;
    endtask
endmodule // tcp_pin_model

// ===== testbench/testbench.sv
// self-checking bench: register access, counters and the third timer
`timescale 1ns/1ps
module testbench;
    logic        clk, arst_n, read, write, ws_n;
    logic [9:0]  address;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [7:0]  rd_n, tmp;
    wire         waitrequest, cmode, p0, p1, g0, g1, dir, tog0, tog1, baud;
    int          bad_count, n_checks;
    logic [7:0]  bauds = 8'h00;

    tcp_pin_model i_pins (.clk(clk), .compat_mode(cmode),
        .timer0_count_pin(p0), .timer1_count_pin(p1),
        .timer0_gate_pin(g0), .timer1_gate_pin(g1),
        .timer2_direction_pin(dir));
    tcp_timer_block i_dut (.clk(clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .compat_mode(cmode),
        .timer0_count_pin(p0), .timer1_count_pin(p1),
        .timer0_gate_pin(g0), .timer1_gate_pin(g1),
        .timer2_direction_pin(dir), .timer0_toggle_out(tog0),
        .timer1_toggle_out(tog1), .baud_tick(baud));

    // clock and settled mid-cycle view of the answer
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        ws_n = waitrequest;
        rd_n = readdata[7:0];
    end
    // overflow pulses seen on the baud output
    always @(posedge clk) begin
        if (baud) bauds <= bauds + 8'h01;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr_en, input logic [7:0] idx,
                       input logic [1:0] lo, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        address <= {idx, lo};
        read <= !wr_en;
        write <= wr_en;
        writedata <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ws_n !== 1'b0 && n < 100);
        rd = rd_n;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 100) bad_count++;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, 2'b00, wd, tmp);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                       input logic [1:0] lo = 2'b00);
        bus(1'b0, idx, lo, 8'h00, tmp);
        check($sformatf("reg %h", idx), tmp, exp);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_checks = 0;
        arst_n = 1'b0;
        {read, write, address, writedata} = '0;
        byteenable = 4'hf;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rdc(8'ha1, 8'h00);
        rdc(8'h88, 8'h00);
        wr(8'h00, 8'h55);
        rdc(8'h00, 8'h00);
        rdc(8'h8a, 8'h00, 2'b01);
        byteenable <= 4'h0;
        wr(8'h8b, 8'haa);
        byteenable <= 4'hf;
        rdc(8'h8b, 8'h00);
        // timer0 as 16-bit counter, wrapping from the top
        wr(8'h89, 8'h05);
        wr(8'h91, 8'h01);
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'hff);
        rdc(8'h8a, 8'hfe);
        wr(8'h88, 8'h10);
        i_pins.falls(3, 1);
        repeat (4) @(posedge clk);
        rdc(8'h8a, 8'h01);
        rdc(8'h8c, 8'h00);
        rdc(8'h88, 8'h30);
        check("toggle0", {7'h0, tog0}, 8'h01);
        // third timer counting up through its top
        wr(8'hca, 8'h00);
        wr(8'hcb, 8'h00);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        i_pins.set_dir(1'b1);
        wr(8'hc8, 8'h38);
        repeat (10) @(posedge clk);
        rdc(8'hc8, 8'hf8);
        rdc(8'hcd, 8'h00);
        // counting down to the reload value
        wr(8'hc8, 8'h18);
        wr(8'hcc, 8'h02);
        wr(8'hcd, 8'h00);
        i_pins.set_dir(1'b0);
        wr(8'hc8, 8'h38);
        repeat (10) @(posedge clk);
        rdc(8'hc8, 8'hf8);
        rdc(8'hcd, 8'hff);
        // timer1 gated 8-bit reload from f0, halted by asking for split
        wr(8'h8d, 8'hf0);
        wr(8'h8b, 8'hfe);
        wr(8'h91, 8'h03);
        wr(8'h89, 8'ha5);
        wr(8'h88, 8'h40);
        wr(8'h89, 8'hb5);
        rdc(8'h8b, 8'hf1);
        rdc(8'h88, 8'hc0);
        check("toggle1", {7'h0, tog1}, 8'h01);
        check("baud", bauds, 8'h01);
        // compatibility strap, paced pin sampling
        i_pins.set_strap(1'b1);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(8'ha1, 8'h5a);
        wr(8'h89, 8'h04);
        wr(8'h88, 8'h10);
        i_pins.falls(4, 12);
        repeat (30) @(posedge clk);
        rdc(8'h8a, 8'h04);
        wrap_up();
    end
endmodule // testbench
